// File: rtl/mmfr_pkg.sv
/*
 Constants and carrier types for the memory model feature identification register.
 Assumes a core pipeline that presents decoded system-register read requests.
*/
// Notes on behaviour
// - 64-bit read-only id register; bits 63:44 and 19:16 read zero.
// - Bits 43:40 return 2: small granule supported at stage two.
// - Bits 39:36 return 2: large granule supported at stage two.
// - Bits 35:32 return 2: mid granule supported at stage two.
// - Bits 31:28 return 0: small granule supported.
// - Bits 27:24 return 0: large granule supported.
// - Bits 23:20 return 1: mid granule supported.
// - Bits 15:12 return 1: secure and non-secure memory distinguished.
// - Bits 11:8 return 1: mixed-endian support, endianness bits configurable.
// - Bits 7:4 return 2: space identifiers are 16 bits wide.
// - Bits 3:0 return 2: physical address range 40 bits.
// - Read decoded at op0 3, op1 0, CRn 0, CRm 7, op2 0.
// - Lowest-level read traps to hypervisor if enabled and general trap, else kernel.
// - Kernel read traps to hypervisor when enabled and id trap set, else returns.
// - Hypervisor and highest level reads return value without trap.
package mmfr_pkg;

   // Privilege levels
   typedef enum logic [1:0] {
      LEVEL_USER,
      LEVEL_KERNEL,
      LEVEL_HYP,
      LEVEL_MONITOR
   } privilege_level_t;

   // Decoded system-register selector
   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } sysreg_sel_t;

   // Read request from the pipeline
   typedef struct packed {
      logic             valid;
      sysreg_sel_t      sel;
      privilege_level_t level;
      logic             hyp_enabled;
      logic             hyp_general_trap;
      logic             hyp_id_trap;
   } read_req_t;

   // Read answer to the pipeline
   typedef struct packed {
      logic        valid;
      logic        hit;
      logic        trap;
      logic [1:0]  trap_level;
      logic [5:0]  trap_class;
      logic [63:0] data;
   } read_rsp_t;

   localparam sysreg_sel_t SEL_MMFR0 = '{op0: 2'h3, op1: 3'h0, crn: 4'h0, crm: 4'h7, op2: 3'h0};
   localparam logic [5:0]  TRAP_CLASS_SYSREG = 6'h18;

   // Field positions (low bit of each 4-bit field)
   localparam int SMALL_GRAN_S2_LSB = 40;
   localparam int LARGE_GRAN_S2_LSB = 36;
   localparam int MID_GRAN_S2_LSB   = 32;
   localparam int SMALL_GRAN_LSB    = 28;
   localparam int LARGE_GRAN_LSB    = 24;
   localparam int MID_GRAN_LSB      = 20;
   localparam int SECURE_MEM_LSB    = 12;
   localparam int MIXED_ENDIAN_LSB  = 8;
   localparam int SPACE_ID_LSB      = 4;
   localparam int PHYS_RANGE_LSB    = 0;

   // Field values
   localparam logic [3:0] SMALL_GRAN_S2_VAL = 4'h2;
   localparam logic [3:0] LARGE_GRAN_S2_VAL = 4'h2;
   localparam logic [3:0] MID_GRAN_S2_VAL   = 4'h2;
   localparam logic [3:0] SMALL_GRAN_VAL    = 4'h0;
   localparam logic [3:0] LARGE_GRAN_VAL    = 4'h0;
   localparam logic [3:0] MID_GRAN_VAL      = 4'h1;
   localparam logic [3:0] SECURE_MEM_VAL    = 4'h1;
   localparam logic [3:0] MIXED_ENDIAN_VAL  = 4'h1;
   localparam logic [3:0] SPACE_ID_VAL      = 4'h2;
   localparam logic [3:0] PHYS_RANGE_VAL    = 4'h2;

   // Assembled register image; reserved bits zero
   localparam logic [63:0] MMFR0_VALUE = {20'h00000,
      SMALL_GRAN_S2_VAL, LARGE_GRAN_S2_VAL, MID_GRAN_S2_VAL,
      SMALL_GRAN_VAL, LARGE_GRAN_VAL, MID_GRAN_VAL, 4'h0,
      SECURE_MEM_VAL, MIXED_ENDIAN_VAL, SPACE_ID_VAL, PHYS_RANGE_VAL};

endpackage

// File: rtl/mmfr_access_check.sv
/*
 Combinational access check for reads of the identification register.
 Assumes the request fields are stable while valid is high.
*/
`timescale 1ns/1ns
module mmfr_access_check (
   input  wire mmfr_pkg::read_req_t req,
   output logic                    hit,
   output logic                    trap,
   output logic [1:0]              trap_level
);

   // Decode selector and work out trap destination
   always_comb begin
      hit        = req.valid && (req.sel == mmfr_pkg::SEL_MMFR0);
      trap       = 1'b0;
      trap_level = 2'h0;
      case (req.level)
         mmfr_pkg::LEVEL_USER: begin
            trap = hit;
            if (req.hyp_enabled && req.hyp_general_trap) begin
               trap_level = mmfr_pkg::LEVEL_HYP;
            end else begin
               trap_level = mmfr_pkg::LEVEL_KERNEL;
            end
         end
         mmfr_pkg::LEVEL_KERNEL: begin
            trap       = hit && req.hyp_enabled && req.hyp_id_trap;
            trap_level = mmfr_pkg::LEVEL_HYP;
         end
         default: begin
            trap = 1'b0;
         end
      endcase
   end

endmodule // mmfr_access_check

// File: rtl/mmfr_id_reg.sv
/*
 Memory model feature identification register with its read access check.
 The image is assembled from per-field placements so that reserved bits can
 only ever read zero; the answer is registered and pulses for one cycle.
 Assumes one decoded read request per cycle; answer one cycle later.
 Assumes the selector and control levels in the request are settled by the
 rising edge on which valid is high.
*/
`timescale 1ns/1ns
module mmfr_id_reg (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire mmfr_pkg::read_req_t req,
   output mmfr_pkg::read_rsp_t      rsp
);

   logic                hit;
   logic                trap;
   logic [1:0]          trap_level;
   mmfr_pkg::read_rsp_t rsp_ff;
   mmfr_pkg::read_rsp_t nxt_rsp;

   // Placement of every defined four-bit field: low bit and fixed value
   localparam int         N_FIELDS = 10;
   localparam int         FIELD_LSB [N_FIELDS] = '{
      mmfr_pkg::SMALL_GRAN_S2_LSB,
      mmfr_pkg::LARGE_GRAN_S2_LSB,
      mmfr_pkg::MID_GRAN_S2_LSB,
      mmfr_pkg::SMALL_GRAN_LSB,
      mmfr_pkg::LARGE_GRAN_LSB,
      mmfr_pkg::MID_GRAN_LSB,
      mmfr_pkg::SECURE_MEM_LSB,
      mmfr_pkg::MIXED_ENDIAN_LSB,
      mmfr_pkg::SPACE_ID_LSB,
      mmfr_pkg::PHYS_RANGE_LSB
   };
   localparam logic [3:0] FIELD_VAL [N_FIELDS] = '{
      mmfr_pkg::SMALL_GRAN_S2_VAL,
      mmfr_pkg::LARGE_GRAN_S2_VAL,
      mmfr_pkg::MID_GRAN_S2_VAL,
      mmfr_pkg::SMALL_GRAN_VAL,
      mmfr_pkg::LARGE_GRAN_VAL,
      mmfr_pkg::MID_GRAN_VAL,
      mmfr_pkg::SECURE_MEM_VAL,
      mmfr_pkg::MIXED_ENDIAN_VAL,
      mmfr_pkg::SPACE_ID_VAL,
      mmfr_pkg::PHYS_RANGE_VAL
   };

   // Register image and one word per placed field
   logic [63:0]         image;
   logic [63:0]         field_word [N_FIELDS];

   // Check helper: first good value answered since reset
   logic                seen_ff;
   logic                nxt_seen;
   logic [63:0]         first_ff;
   logic [63:0]         nxt_first;

   mmfr_access_check u_check (
      .req        (req),
      .hit        (hit),
      .trap       (trap),
      .trap_level (trap_level)
   );

   // Put each field at its own position in an otherwise empty word
   for (genvar g = 0; g < N_FIELDS; g++) begin : gen_field
      assign field_word[g] = 64'(FIELD_VAL[g]) << FIELD_LSB[g];
   end

   // Merge the placed fields; bits that no field covers stay zero
   always_comb begin
      image = 64'h0;
      for (int i = 0; i < N_FIELDS; i++) begin
         image = image | field_word[i];
      end
   end

   // Form the answer; data is the fixed image, never written, on an untrapped hit, else zero
   always_comb begin
      nxt_rsp            = '0;
      nxt_rsp.valid      = req.valid;
      nxt_rsp.hit        = hit;
      nxt_rsp.trap       = trap;
      if (trap) begin
         nxt_rsp.trap_level = trap_level;
         nxt_rsp.trap_class = mmfr_pkg::TRAP_CLASS_SYSREG;
      end else if (hit) begin
         nxt_rsp.data = image;
      end
   end

   // Answer register
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff <= nxt_rsp;
      end
   end

   assign rsp = rsp_ff;

   // Capture the first good value answered; later reads are held against it,
   // which catches a value that drifts between reads that are far apart
   always_comb begin
      nxt_seen  = seen_ff;
      nxt_first = first_ff;
      if (rsp.valid && rsp.hit && !rsp.trap && !seen_ff) begin
         nxt_seen  = 1'b1;
         nxt_first = rsp.data;
      end
   end

   // Helper registers, cleared with the answer
   always_ff @(posedge clk) begin
      if (rst) begin
         seen_ff  <= 1'b0;
         first_ff <= 64'h0;
      end else begin
         seen_ff  <= nxt_seen;
         first_ff <= nxt_first;
      end
   end

   // Checks on the whole answer value and on the reserved bits
   property hit_data_p;
      @(posedge clk) disable iff (rst)
      (hit && !trap) |=> (rsp.valid && rsp.hit && rsp.data == 64'h0000_0222_0010_1122);
   endproperty
   image_value_a: assert property (hit_data_p) else $error("wrong id value");
   image_build_a: assert property (@(posedge clk) disable iff (rst)
      image == 64'h0000_0222_0010_1122)
      else $error("image assembly wrong");
   reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
      rsp.valid |-> rsp.data[63:44] == 20'h00000 && rsp.data[19:16] == 4'h0)
      else $error("reserved bits set");

   // Checks on the individual fields of a returned value
   small_s2_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[43:40] == 4'h2)
      else $error("small stage two field");
   large_s2_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[39:36] == 4'h2)
      else $error("large stage two field");
   mid_s2_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[35:32] == 4'h2)
      else $error("mid stage two field");
   small_gran_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[31:28] == 4'h0)
      else $error("small granule field");
   large_gran_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[27:24] == 4'h0)
      else $error("large granule field");
   mid_gran_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[23:20] == 4'h1)
      else $error("mid granule field");
   secure_mem_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[15:12] == 4'h1)
      else $error("secure memory field");
   mixed_endian_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[11:8] == 4'h1)
      else $error("mixed endian field");
   space_id_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[7:4] == 4'h2)
      else $error("space id field");
   phys_range_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap |-> rsp.data[3:0] == 4'h2)
      else $error("physical range field");

   // Checks on decoding and on the shape of the answer
   decode_hit_a: assert property (@(posedge clk) disable iff (rst)
      req.valid && req.sel.crm == 4'h7 && req.sel.op0 == 2'h3 && req.sel.op1 == 3'h0
      && req.sel.crn == 4'h0 && req.sel.op2 == 3'h0 |=> rsp.hit)
      else $error("decode missed");
   miss_quiet_a: assert property (@(posedge clk) disable iff (rst)
      rsp.valid && !rsp.hit |-> !rsp.trap && rsp.data == 64'h0)
      else $error("refused read answered");
   valid_follow_a: assert property (@(posedge clk) disable iff (rst)
      req.valid |=> rsp.valid)
      else $error("read not answered");
   idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !req.valid |=> !rsp.valid)
      else $error("answer without read");

   // Checks on trapping by privilege level
   user_trap_a: assert property (@(posedge clk) disable iff (rst)
      hit && req.level == mmfr_pkg::LEVEL_USER |=> rsp.trap && rsp.trap_class == 6'h18
      && rsp.trap_level == (($past(req.hyp_enabled) && $past(req.hyp_general_trap)) ? 2'h2 : 2'h1))
      else $error("user trap wrong");
   trap_empty_a: assert property (@(posedge clk) disable iff (rst)
      rsp.trap |-> rsp.hit && rsp.trap_class == 6'h18 && rsp.data == 64'h0)
      else $error("trap carries data");
   kernel_trap_a: assert property (@(posedge clk) disable iff (rst)
      hit && req.level == mmfr_pkg::LEVEL_KERNEL |=> rsp.trap == ($past(req.hyp_enabled) && $past(req.hyp_id_trap)))
      else $error("kernel trap wrong");
   kernel_dest_a: assert property (@(posedge clk) disable iff (rst)
      hit && trap && req.level == mmfr_pkg::LEVEL_KERNEL |=> rsp.trap_level == 2'h2 && rsp.trap_class == 6'h18)
      else $error("kernel trap level wrong");
   high_no_trap_a: assert property (@(posedge clk) disable iff (rst)
      hit && req.level[1] |=> !rsp.trap && rsp.data == mmfr_pkg::MMFR0_VALUE)
      else $error("high level trapped");
   hyp_read_a: assert property (@(posedge clk) disable iff (rst)
      hit && req.level == mmfr_pkg::LEVEL_HYP |=> rsp.hit && !rsp.trap && rsp.data == 64'h0000_0222_0010_1122)
      else $error("hypervisor read wrong");
   monitor_read_a: assert property (@(posedge clk) disable iff (rst)
      hit && req.level == mmfr_pkg::LEVEL_MONITOR |=> rsp.hit && !rsp.trap && rsp.data == 64'h0000_0222_0010_1122)
      else $error("highest level read wrong");

   // Checks that the value never changes and that reset clears the answer
   stable_value_a: assert property (@(posedge clk) disable iff (rst)
      rsp.hit && !rsp.trap ##1 rsp.hit && !rsp.trap |-> $stable(rsp.data))
      else $error("value changed");
   value_kept_a: assert property (@(posedge clk) disable iff (rst)
      seen_ff && rsp.hit && !rsp.trap |-> rsp.data == first_ff)
      else $error("value differs from first read");
   reset_clear_a: assert property (@(posedge clk)
      rst |=> !rsp.valid && !rsp.trap && rsp.data == 64'h0)
      else $error("answer not cleared by reset");

   // Main scenarios that the bench should reach
   user_read_c: cover property (@(posedge clk) hit && req.level == mmfr_pkg::LEVEL_USER);
   kernel_trap_c: cover property (@(posedge clk) hit && trap && req.level == mmfr_pkg::LEVEL_KERNEL);
   kernel_read_c: cover property (@(posedge clk) hit && !trap && req.level == mmfr_pkg::LEVEL_KERNEL);
   back_to_back_c: cover property (@(posedge clk) hit ##1 hit);
   miss_read_c: cover property (@(posedge clk) req.valid && !hit);

endmodule // mmfr_id_reg

// File: tb/tb_mmfr_id_reg.sv
/*
 Self-checking bench for the memory model feature identification register.
 Assumes the package and register module from rtl/ are compiled first.
*/
`timescale 1ns/1ns
module tb_mmfr_id_reg;
   typedef struct packed {
      mmfr_pkg::read_req_t req;
      mmfr_pkg::read_rsp_t rsp;
   } row_t;
   localparam logic [63:0] IMAGE = 64'h0000022200101122;
   localparam mmfr_pkg::sysreg_sel_t SEL = '{2'h3, 3'h0, 4'h0, 4'h7, 3'h0};
   logic                clk;
   logic                rst;
   mmfr_pkg::read_req_t req;
   mmfr_pkg::read_rsp_t rsp;
   int                  bad_count;
   int                  n_compared;
   row_t                rows [$];

   mmfr_id_reg mmfr_id_reg_inst (.clk(clk), .rst(rst), .req(req), .rsp(rsp));

   // Free-running clock, 10 ns period
   always #5 clk = ~clk;

   // Builds one row: request and the answer it should give
   function automatic row_t mk(mmfr_pkg::sysreg_sel_t s, logic [1:0] lv, logic en, logic gt, logic it,
                               logic hit, logic trap, logic [1:0] tl);
      row_t r;
      r.req = '{1'b1, s, mmfr_pkg::privilege_level_t'(lv), en, gt, it};
      r.rsp = '{1'b1, hit, trap, tl, trap ? 6'h18 : 6'h00, (hit && !trap) ? IMAGE : 64'h0};
      return r;
   endfunction

   // Whole answer compare
   task automatic check_rsp(mmfr_pkg::read_rsp_t exp, string what);
      n_compared++;
      if (rsp !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, rsp, exp);
      end
   endtask

   // Single flag compare
   task automatic check_bit(logic got, logic exp, string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %b", $time, what, got);
      end
   endtask

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 30 cycles
   initial begin
      #20000;
      bad_count++;
      $display("BAD %0t watchdog expired", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      bad_count = 0;
      n_compared = 0;
      rows.push_back(mk(SEL, 2'h2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0));
      rows.push_back(mk(SEL, 2'h3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0));
      rows.push_back(mk(SEL, 2'h1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h2));
      rows.push_back(mk(SEL, 2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0));
      rows.push_back(mk(SEL, 2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0));
      rows.push_back(mk(SEL, 2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2));
      rows.push_back(mk(SEL, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h1));
      rows.push_back(mk(SEL, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h1));
      rows.push_back(mk('{2'h2, 3'h0, 4'h0, 4'h7, 3'h0}, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
      rows.push_back(mk('{2'h3, 3'h1, 4'h0, 4'h7, 3'h0}, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
      rows.push_back(mk('{2'h3, 3'h0, 4'h1, 4'h7, 3'h0}, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0));
      rows.push_back(mk('{2'h3, 3'h0, 4'h0, 4'h6, 3'h0}, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
      rows.push_back(mk('{2'h3, 3'h0, 4'h0, 4'h7, 3'h1}, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
      rows.push_back(mk(SEL, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0));
      // A request held during reset must give no answer
      req = rows[0].req;
      repeat (10) @(posedge clk);
      #1;
      check_rsp('0, "during reset");
      rst = 1'b0;
      req = '0;
      @(posedge clk);
      #1;
      check_rsp('0, "after release");
      $display("reset test done");
      // Back-to-back table: each edge launches one row and answers the previous
      for (int i = 0; i <= rows.size(); i++) begin
         @(posedge clk);
         #1;
         if (i > 0) check_rsp(rows[i-1].rsp, "row");
         req = (i < rows.size()) ? rows[i].req : '0;
      end
      $display("table test done");
      @(posedge clk);
      #1;
      check_bit(rsp.valid, 1'b0, "idle answer");
      // Reset in mid-run, then the value must come back unchanged
      rst = 1'b1;
      req = rows[2].req;
      @(posedge clk);
      #1;
      check_rsp('0, "mid reset");
      rst = 1'b0;
      req = '0;
      @(posedge clk);
      #1;
      req = rows[0].req;
      @(posedge clk);
      #1;
      check_rsp(rows[0].rsp, "read after reset");
      req = '0;
      $display("mid-run reset test done");
      wrap_up();
   end
endmodule // tb_mmfr_id_reg
